// ---- include/assl_pkg.sv ----
// package for the axis status and enable block: register map, fields, codes
// assumes one 100 MHz clock and a synchronous active-high reset
// Overview of operation
// - watchdog byte reads 1 after reset
// - machine function cleared, plain binary
// - positive machine function output at completion
// - negative machine function output at start
// - value 1000 outputs no machine function
// - new code replaces old, 0..999, 12 bits
// - three flags compare position to stored
// - positive flag: set rising, clear falling
// - negative flag: set falling, clear rising
// - section flags all one, cleared at start
// - k eighths covered sets flags 1..k
// - enable abort clears, modes 2/3 reset
// - actual position is signed 32 bit absolute
// - error cleared, overwritten, 0FFFFH unknown
// - low limit input brakes, raises error
// - leave limit in ref, manual and ext-ref modes
// - reference input zeroes position in homing
// - enable low refuses start, error 20
// - mode 1 enable fall stops, resume
// - mode 1 idle fall, brake 1: setpoint copy
// - mode 2 fall aborts, restores power-on outputs
// - mode 3 also disables position control
package assl_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_CMD     = 8'h04;
	localparam logic [7:0] ADDR_SETMF   = 8'h08;
	localparam logic [7:0] ADDR_TARGET  = 8'h0C;
	localparam logic [7:0] ADDR_FLAG1   = 8'h10;
	localparam logic [7:0] ADDR_FLAG2   = 8'h14;
	localparam logic [7:0] ADDR_FLAG3   = 8'h18;
	localparam logic [7:0] ADDR_STATUS  = 8'h1C;
	localparam logic [7:0] ADDR_MFUNC   = 8'h20;
	localparam logic [7:0] ADDR_ACTPOS  = 8'h24;
	localparam logic [7:0] ADDR_ERRNUM  = 8'h28;
	localparam logic [7:0] ADDR_SETPT   = 8'h2C;
	localparam logic [7:0] ADDR_ERRSET  = 8'h30;
	// ------------------------------------------------------------
	// fields and codes
	// ------------------------------------------------------------
	localparam int CTRL_EMODE_LO = 0;
	localparam int CTRL_BRAKE    = 2;
	localparam int CTRL_OPMODE   = 3;
	localparam int CMD_START     = 0;
	localparam int CMD_ERRCLR    = 1;
	localparam int MF_SIGN       = 12;
	localparam logic [7:0]  WATCHDOG_INIT = 8'h01;
	localparam logic [11:0] MF_NONE       = 12'h3E8;
	localparam logic [11:0] MF_MAX        = 12'h3E7;
	localparam logic [15:0] ERR_ENABLE    = 16'h0014;
	localparam logic [15:0] ERR_LIMPOS    = 16'h0015;
	localparam logic [15:0] ERR_LIMNEG    = 16'h0016;
	localparam logic [15:0] ERR_UNKNOWN   = 16'hFFFF;
	localparam logic [7:0]  SECT_ALL      = 8'hFF;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
	typedef enum logic [1:0] {
		ASSL_OP_EXT    = 2'b00,
		ASSL_OP_REF    = 2'b01,
		ASSL_OP_MANUAL = 2'b10,
		ASSL_OP_EXTREF = 2'b11
	} assl_op_t;
	typedef enum logic [1:0] {
		ASSL_IDLE  = 2'b00,
		ASSL_RUN   = 2'b01,
		ASSL_HALT  = 2'b10,
		ASSL_OFF   = 2'b11
	} assl_state_t;
endpackage

// ---- logic/assl_top.sv ----
// axis status and enable logic with an AXI4-Lite register slave
// assumes the position feedback and direction come from the drive each cycle
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
module assl_top
	import assl_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// initiators
	input  wire logic        enableIn,
	input  wire logic        limitPosIn,
	input  wire logic        limitNegIn,
	input  wire logic        refPointIn,
	// position feedback
	input  wire logic        stepValid,
	input  wire logic        stepUp,
	input  wire logic        unknownErr,
	// drive outputs
	output logic             brakeOut,
	output logic             posCtrlOn,
	output logic             moveUp,
	output logic             moveDown,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [4:0]         ctrl_reg;
	logic [12:0]        setMf_reg;
	logic signed [31:0] target_reg;
	logic signed [31:0] flagPos_reg [3];
	logic [7:0]         watchdog_reg;
	logic [11:0]        mfunc_reg;
	logic [2:0]         flags_reg;
	logic [7:0]         sect_reg;
	logic signed [31:0] actPos_reg;
	logic signed [31:0] prevPos_reg;
	logic signed [31:0] setpt_reg;
	logic signed [31:0] startPos_reg;
	logic [15:0]        errNum_reg;
	logic               setDone_reg;
	logic               startQuit_reg;
	logic               enable_reg;
	assl_state_t        state_reg;
	logic [7:0]         awAddr_reg;
	logic               awHave_reg;
	logic [31:0]        wData_reg;
	logic [3:0]         wStrb_reg;
	logic               wHave_reg;

	logic [1:0]  emode;
	logic        enableFall;
	logic        limitHit;
	logic        leaveOk;
	logic        wrFire;
	logic        startReq;
	logic        errClr;
	logic        errSetReq;
	logic [15:0] errSetVal;
	logic        startOk;
	logic        finish;
	logic signed [32:0] travel;
	logic signed [32:0] covered;
	logic [31:0] absTravel;
	logic [31:0] absCovered;

	// ------------------------------------------------------------
	// decode of control fields
	// ------------------------------------------------------------
	// codes 0 and 3 both mean mode 1; internal mode 0 means mode 1
	assign emode = (ctrl_reg[1:0] == 2'b11) ? 2'b00 : ctrl_reg[1:0];
	assign enableFall = enable_reg & ~enableIn;
	assign limitHit = ~limitPosIn | ~limitNegIn;
	assign leaveOk = (ctrl_reg[4:3] != ASSL_OP_EXT);
	assign wrFire = awHave_reg & wHave_reg & ~s_axi_bvalid;
	assign startReq = wrFire & (awAddr_reg == ADDR_CMD) & wStrb_reg[0] & wData_reg[CMD_START];
	assign errClr = wrFire & (awAddr_reg == ADDR_CMD) & wStrb_reg[0] & wData_reg[CMD_ERRCLR];
	assign startOk = startReq & enableIn & (~limitHit | leaveOk);
	assign travel = 33'(target_reg) - 33'(startPos_reg);
	assign covered = 33'(actPos_reg) - 33'(startPos_reg);
	assign absTravel = travel[32] ? 32'(-travel) : 32'(travel);
	assign absCovered = covered[32] ? 32'(-covered) : 32'(covered);
	assign finish = (state_reg == ASSL_RUN) & (actPos_reg == setpt_reg);

	// ------------------------------------------------------------
	// drive outputs
	// ------------------------------------------------------------
	// position control is gated off in mode 3 while enable is low
	assign posCtrlOn = (state_reg != ASSL_OFF);
	assign brakeOut = (state_reg == ASSL_HALT) | (limitHit & ~leaveOk);
	assign moveUp = (state_reg == ASSL_RUN) & (setpt_reg > actPos_reg);
	assign moveDown = (state_reg == ASSL_RUN) & (setpt_reg < actPos_reg);

	// ------------------------------------------------------------
	// set sequencer
	// ------------------------------------------------------------
	// enable is sampled so a fall is seen even between starts;
	// history starts low so leaving reset never looks like a fall
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_reg    <= 1'b0;
			state_reg     <= ASSL_IDLE;
			setDone_reg   <= 1'b1;
			startQuit_reg <= 1'b0;
			setpt_reg     <= '0;
			startPos_reg  <= '0;
		end else begin
			enable_reg <= enableIn;
			if (enableFall) begin
				if (emode == 2'b00) begin
					if (state_reg == ASSL_RUN)
						state_reg <= ASSL_HALT;
					if (setDone_reg & ctrl_reg[CTRL_BRAKE])
						setpt_reg <= actPos_reg;
				end else begin
					state_reg   <= (emode == 2'b10) ? ASSL_OFF : ASSL_IDLE;
					setDone_reg <= 1'b1;
					setpt_reg   <= actPos_reg;
				end
			end else if (startOk) begin
				// a halted set resumes toward its old target
				if (state_reg != ASSL_HALT) begin
					startPos_reg <= actPos_reg;
					setpt_reg    <= target_reg;
				end
				state_reg     <= ASSL_RUN;
				setDone_reg   <= 1'b0;
				startQuit_reg <= 1'b1;
			end else if (finish) begin
				state_reg   <= ASSL_IDLE;
				setDone_reg <= 1'b1;
			end else if (state_reg == ASSL_OFF && enableIn) begin
				state_reg <= ASSL_IDLE;
			end
			if (startReq == 1'b0 && wrFire && awAddr_reg == ADDR_STATUS && wStrb_reg[1])
				startQuit_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// actual position counter
	// ------------------------------------------------------------
	// keeps counting in every state, also with control disabled
	always_ff @(posedge clk) begin
		if (rst) begin
			actPos_reg  <= '0;
			prevPos_reg <= '0;
		end else begin
			prevPos_reg <= actPos_reg;
			if (refPointIn && ctrl_reg[4:3] inside {ASSL_OP_REF, ASSL_OP_EXTREF})
				actPos_reg <= '0;
			else if (stepValid)
				actPos_reg <= stepUp ? actPos_reg + 32'sd1 : actPos_reg - 32'sd1;
		end
	end

	// ------------------------------------------------------------
	// watchdog and machine function
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			watchdog_reg <= WATCHDOG_INIT;
			mfunc_reg    <= '0;
		end else if (setMf_reg[11:0] != MF_NONE && setMf_reg[11:0] <= MF_MAX) begin
			if (startOk && setMf_reg[MF_SIGN] && state_reg != ASSL_HALT)
				mfunc_reg <= setMf_reg[11:0];
			else if (finish && !setMf_reg[MF_SIGN] && !enableFall)
				mfunc_reg <= setMf_reg[11:0];
		end
	end

	// ------------------------------------------------------------
	// crossing flags
	// ------------------------------------------------------------
	// a crossing is a sign change of position minus flag position
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_reg <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (prevPos_reg < flagPos_reg[i] && actPos_reg >= flagPos_reg[i])
					flags_reg[i] <= ~flagPos_reg[i][31];
				else if (prevPos_reg >= flagPos_reg[i] && actPos_reg < flagPos_reg[i])
					flags_reg[i] <= flagPos_reg[i][31];
			end
		end
	end

	// ------------------------------------------------------------
	// section flags
	// ------------------------------------------------------------
	// compare 8*covered against k*travel, avoiding a divider
	always_ff @(posedge clk) begin
		if (rst) begin
			sect_reg <= SECT_ALL;
		end else if (enableFall) begin
			if (emode == 2'b00)
				sect_reg <= '0;
			else
				sect_reg <= SECT_ALL;
		end else if (startOk && state_reg != ASSL_HALT) begin
			sect_reg <= '0;
		end else if (state_reg == ASSL_RUN) begin
			for (int k = 1; k <= 8; k++) begin
				if ({3'b000, absCovered} * 35'd8 >= {3'b000, absTravel} * 35'(k))
					sect_reg[k-1] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// error number
	// ------------------------------------------------------------
	// a new error beats a clear in the same cycle
	assign errSetReq = (startReq & ~enableIn) | limitHit | unknownErr |
		(wrFire & (awAddr_reg == ADDR_ERRSET));
	assign errSetVal = (startReq & ~enableIn) ? ERR_ENABLE :
		(~limitPosIn) ? ERR_LIMPOS : (~limitNegIn) ? ERR_LIMNEG :
		unknownErr ? ERR_UNKNOWN : wData_reg[15:0];
	always_ff @(posedge clk) begin
		if (rst)
			errNum_reg <= '0;
		else if (errSetReq)
			errNum_reg <= errSetVal;
		else if (errClr)
			errNum_reg <= '0;
	end

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	assign s_axi_awready = ~awHave_reg;
	assign s_axi_wready = ~wHave_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			awHave_reg   <= 1'b0;
			wHave_reg    <= 1'b0;
			awAddr_reg   <= '0;
			wData_reg    <= '0;
			wStrb_reg    <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !awHave_reg) begin
				awAddr_reg <= s_axi_awaddr;
				awHave_reg <= 1'b1;
			end
			if (s_axi_wvalid && !wHave_reg) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
				wHave_reg <= 1'b1;
			end
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr_reg[1:0] == 2'b00 && awAddr_reg <= ADDR_ERRSET) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHave_reg   <= 1'b0;
				wHave_reg    <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// only byte lane 0..3 writes land; status words are read only, except a lane 1 write to ADDR_STATUS clears startQuit_reg
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg    <= '0;
			setMf_reg   <= {1'b0, MF_NONE};
			target_reg  <= '0;
			flagPos_reg <= '{default: '0};
		end else if (wrFire) begin
			for (int b = 0; b < 4; b++) begin
				if (wStrb_reg[b]) begin
					unique case (awAddr_reg)
						ADDR_TARGET: target_reg[8*b +: 8] <= wData_reg[8*b +: 8];
						ADDR_FLAG1:  flagPos_reg[0][8*b +: 8] <= wData_reg[8*b +: 8];
						ADDR_FLAG2:  flagPos_reg[1][8*b +: 8] <= wData_reg[8*b +: 8];
						ADDR_FLAG3:  flagPos_reg[2][8*b +: 8] <= wData_reg[8*b +: 8];
						default: ;
					endcase
				end
			end
			if (awAddr_reg == ADDR_CTRL && wStrb_reg[0])
				ctrl_reg <= wData_reg[4:0];
			if (awAddr_reg == ADDR_SETMF && wStrb_reg[0])
				setMf_reg[7:0] <= wData_reg[7:0];
			if (awAddr_reg == ADDR_SETMF && wStrb_reg[1])
				setMf_reg[12:8] <= wData_reg[12:8];
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CTRL:   s_axi_rdata <= {27'd0, ctrl_reg};
				ADDR_CMD:    s_axi_rdata <= '0;
				ADDR_SETMF:  s_axi_rdata <= {19'd0, setMf_reg};
				ADDR_TARGET: s_axi_rdata <= target_reg;
				ADDR_FLAG1:  s_axi_rdata <= flagPos_reg[0];
				ADDR_FLAG2:  s_axi_rdata <= flagPos_reg[1];
				ADDR_FLAG3:  s_axi_rdata <= flagPos_reg[2];
				ADDR_STATUS: s_axi_rdata <= {watchdog_reg, sect_reg, 5'd0, flags_reg,
					~limitNegIn, ~limitPosIn, posCtrlOn, brakeOut,
					startQuit_reg, setDone_reg, state_reg};
				ADDR_MFUNC:  s_axi_rdata <= {20'd0, mfunc_reg};
				ADDR_ACTPOS: s_axi_rdata <= actPos_reg;
				ADDR_ERRNUM: s_axi_rdata <= {16'd0, errNum_reg};
				ADDR_SETPT:  s_axi_rdata <= setpt_reg;
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_watchdog_init: assert property (
		@(posedge clk) $fell(rst) |-> watchdog_reg == WATCHDOG_INIT)
		else $error("watchdog not one after reset");
	a_mfunc_reset: assert property (
		@(posedge clk) $past(rst) |-> mfunc_reg == 12'h000)
		else $error("machine function not cleared");
	a_mfunc_range: assert property (
		@(posedge clk) disable iff (rst) mfunc_reg <= MF_MAX)
		else $error("machine function out of range");
	a_sect_clear: assert property (@(posedge clk) disable iff (rst)
		(startOk && state_reg == ASSL_IDLE && !enableFall) |=> sect_reg == 8'h00)
		else $error("section flags not cleared at start");
	a_enable_refuse: assert property (@(posedge clk) disable iff (rst)
		(startReq && !enableIn) |=> state_reg != ASSL_RUN || $past(state_reg) == ASSL_RUN)
		else $error("start taken with enable low");
	a_err_enable: assert property (@(posedge clk) disable iff (rst)
		(startReq && !enableIn) |=> errNum_reg == ERR_ENABLE)
		else $error("error 20 not reported");
	a_mode2_restore: assert property (@(posedge clk) disable iff (rst)
		(enableFall && emode == 2'b01) |=> setDone_reg && sect_reg == SECT_ALL &&
		setpt_reg == $past(actPos_reg))
		else $error("mode 2 outputs not restored");
	a_mode3_off: assert property (@(posedge clk) disable iff (rst)
		(enableFall && emode == 2'b10) |=> !posCtrlOn)
		else $error("mode 3 control still on");
	a_ref_zero: assert property (@(posedge clk) disable iff (rst)
		(refPointIn && ctrl_reg[4:3] == ASSL_OP_REF) |=> actPos_reg == 32'sd0)
		else $error("reference did not zero position");
	a_idle_copy: assert property (@(posedge clk) disable iff (rst)
		(enableFall && emode == 2'b00 && setDone_reg && ctrl_reg[CTRL_BRAKE])
		|=> setpt_reg == $past(actPos_reg))
		else $error("idle fall did not copy position");
endmodule

// ---- test/assl_drive_model.sv ----
// drive model: moves the axis one count per gap toward the setpoint
// assumes moveUp/moveDown from the block and a synchronous active-high reset
module assl_drive_model #(
	parameter int STEP_GAP = 10
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// stall request from the bench
	input  wire logic hold,
	// block side
	input  wire logic moveUp,
	input  wire logic moveDown,
	output logic      stepValid,
	output logic      stepUp
);
	timeunit 1ns;
	timeprecision 1ns;
	int gapCnt;
	// direction toggles between pulses, so nobody may trust it outside a pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			stepValid <= 1'h0;
			stepUp    <= 1'h0;
			gapCnt    <= 0;
		end else begin
			stepValid <= 1'h0;
			stepUp    <= ~stepUp;
			gapCnt    <= (gapCnt == STEP_GAP - 1) ? 0 : gapCnt + 1;
			if (gapCnt == STEP_GAP - 1 && !hold && (moveUp || moveDown)) begin
				stepValid <= 1'h1;
				stepUp    <= moveUp;
			end
		end
	end
endmodule

// ---- test/tb.sv ----
// self-checking bench for the axis status and enable block
// assumes the drive model closes the position loop; bus is AXI4-Lite
`define CHK(got, exp, msg) begin testsRun++; if ((got) !== (exp)) begin mismatches++; \
	$display("CHECK FAILED at %0t: %s", $time, msg); end end
module tb;
	import assl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst, enableIn, limitPosIn, limitNegIn, refPointIn, unknownErr, hold;
	logic        stepValid, stepUp, brakeOut, posCtrlOn, moveUp, moveDown;
	logic        awValid, awReady, wValid, wReady, bValid, bReady;
	logic        arValid, arReady, rValid, rReady;
	logic [7:0]  awAddr, arAddr;
	logic [31:0] wData, rData, rdVal, posVal;
	logic [3:0]  wStrb;
	logic [1:0]  bResp, rResp, rdResp;
	int          mismatches, testsRun, cycles;

	assl_top dut (.clk(clk), .rst(rst), .enableIn(enableIn), .limitPosIn(limitPosIn),
		.limitNegIn(limitNegIn), .refPointIn(refPointIn), .stepValid(stepValid),
		.stepUp(stepUp), .unknownErr(unknownErr), .brakeOut(brakeOut), .posCtrlOn(posCtrlOn),
		.moveUp(moveUp), .moveDown(moveDown), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
	assl_drive_model drv (.clk(clk), .rst(rst), .hold(hold), .moveUp(moveUp),
		.moveDown(moveDown), .stepValid(stepValid), .stepUp(stepUp));

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	// each channel released only at the edge that takes it; ready lines stay up
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		awAddr <= a;
		wData <= d;
		wStrb <= 4'hF;
		awValid <= 1'h1;
		wValid <= 1'h1;
		bReady <= 1'h1;
		do begin
			@(posedge clk);
			if (awReady) awValid <= 1'h0;
			if (wReady) wValid <= 1'h0;
		end while (bValid !== 1'h1);
	endtask
	task automatic axiRead(input logic [7:0] a);
		arAddr <= a;
		arValid <= 1'h1;
		rReady <= 1'h1;
		do begin
			@(posedge clk);
			if (arReady) arValid <= 1'h0;
		end while (rValid !== 1'h1);
		rdVal = rData;
		rdResp = rResp;
	endtask
	task automatic regCheck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		axiRead(a);
		`CHK(rdVal & m, e, "register read")
	endtask
	task automatic startSet(input logic [31:0] tgt, input logic [31:0] mf);
		axiWrite(ADDR_SETMF, mf);
		axiWrite(ADDR_TARGET, tgt);
		axiWrite(ADDR_CMD, 32'h1);
	endtask
	// polls set-executed; the cycle ceiling cuts a hang short
	task automatic waitDone;
		do axiRead(ADDR_STATUS); while (rdVal[2] !== 1'h1);
	endtask
	task automatic giveVerdict;
		if (mismatches == 0 && testsRun > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			mismatches++;
			giveVerdict();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst, limitPosIn, limitNegIn} = 3'h7;
		{enableIn, refPointIn, unknownErr, hold} = 4'h0;
		{awValid, wValid, bReady, arValid, rReady} = 5'h0;
		{awAddr, arAddr, wData, wStrb} = 52'h0;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		regCheck(ADDR_STATUS, 32'hFF000000, 32'h01000000);
		regCheck(ADDR_STATUS, 32'h00FF0004, 32'h00FF0004);
		regCheck(ADDR_MFUNC, 32'hFFFFFFFF, 32'h0);
		regCheck(ADDR_ERRNUM, 32'hFFFF, 32'h0);
		regCheck(ADDR_SETMF, 32'h1FFF, {20'h0, MF_NONE});
		axiRead(8'h40);
		`CHK(rdResp, RESP_SLVERR, "unmapped read")
		// refused start, then error overwrite and clear
		axiWrite(ADDR_CMD, 32'h1);
		regCheck(ADDR_ERRNUM, 32'hFFFF, {16'h0, ERR_ENABLE});
		regCheck(ADDR_STATUS, 32'h3, 32'h0);
		axiWrite(ADDR_ERRSET, 32'h1234);
		regCheck(ADDR_ERRNUM, 32'hFFFF, 32'h1234);
		unknownErr <= 1'h1;
		@(posedge clk);
		unknownErr <= 1'h0;
		regCheck(ADDR_ERRNUM, 32'hFFFF, {16'h0, ERR_UNKNOWN});
		axiWrite(ADDR_CMD, 32'h2);
		regCheck(ADDR_ERRNUM, 32'hFFFF, 32'h0);
		// sets with machine functions and flag crossings
		enableIn <= 1'h1;
		axiWrite(ADDR_CTRL, 32'h0);
		axiWrite(ADDR_FLAG1, 32'h8);
		axiWrite(ADDR_FLAG2, 32'hFFFFFFFC);
		axiWrite(ADDR_FLAG3, 32'h64);
		startSet(32'h10, 32'h5);
		regCheck(ADDR_STATUS, 32'h00FF0000, 32'h0);
		regCheck(ADDR_MFUNC, 32'hFFF, 32'h0);
		waitDone;
		regCheck(ADDR_MFUNC, 32'hFFF, 32'h5);
		regCheck(ADDR_STATUS, 32'h00FF0700, 32'h00FF0100);
		regCheck(ADDR_ACTPOS, 32'hFFFFFFFF, 32'h10);
		startSet(32'hFFFFFFF8, 32'h1007);
		regCheck(ADDR_MFUNC, 32'hFFF, 32'h7);
		waitDone;
		regCheck(ADDR_STATUS, 32'h700, 32'h200);
		regCheck(ADDR_ACTPOS, 32'hFFFFFFFF, 32'hFFFFFFF8);
		startSet(32'h0, {20'h0, MF_NONE});
		waitDone;
		regCheck(ADDR_MFUNC, 32'hFFF, 32'h7);
		regCheck(ADDR_STATUS, 32'h700, 32'h0);
		// enable fall mid-run under every mode code; the drive is stalled two
		// cycles ahead so no count is in flight when the setpoint is copied
		for (int c = 0; c < 4; c++) begin
			axiWrite(ADDR_CTRL, 32'(c));
			startSet(32'h28 * 32'(c + 1), 32'h3E8);
			repeat (60) @(posedge clk);
			hold <= 1'h1;
			repeat (2) @(posedge clk);
			enableIn <= 1'h0;
			repeat (3) @(posedge clk);
			axiRead(ADDR_STATUS);
			if (c == 1 || c == 2) begin
				`CHK(rdVal & 32'h00FF0004, 32'h00FF0004, "abort restore")
				`CHK(posCtrlOn, (c == 2) ? 1'h0 : 1'h1, "control off")
				axiRead(ADDR_SETPT);
				posVal = rdVal;
				axiRead(ADDR_ACTPOS);
				`CHK(posVal, rdVal, "setpoint copy")
				enableIn <= 1'h1;
				hold <= 1'h0;
			end else begin
				`CHK(rdVal & 32'h00FF0003, 32'h2, "halted")
				`CHK(brakeOut, 1'h1, "brake on fall")
				enableIn <= 1'h1;
				hold <= 1'h0;
				axiWrite(ADDR_CMD, 32'h1);
				waitDone;
				regCheck(ADDR_ACTPOS, 32'hFFFFFFFF, 32'h28 * 32'(c + 1));
			end
		end
		`CHK(posCtrlOn, 1'h1, "control back")
		regCheck(ADDR_STATUS, 32'h700, 32'h500);
		// idle fall with brake setting 1: zero the position first so the copy shows
		axiWrite(ADDR_CTRL, 32'hC);
		refPointIn <= 1'h1;
		@(posedge clk);
		refPointIn <= 1'h0;
		axiWrite(ADDR_CTRL, 32'h4);
		enableIn <= 1'h0;
		repeat (2) @(posedge clk);
		enableIn <= 1'h1;
		regCheck(ADDR_SETPT, 32'hFFFFFFFF, 32'h0);
		startSet(32'h20, 32'h3E8);
		waitDone;
		// homing with the drive stalled so the zeroing is visible
		hold <= 1'h1;
		axiWrite(ADDR_CTRL, 32'h8);
		startSet(32'h0, 32'h3E8);
		refPointIn <= 1'h1;
		repeat (2) @(posedge clk);
		refPointIn <= 1'h0;
		regCheck(ADDR_ACTPOS, 32'hFFFFFFFF, 32'h0);
		hold <= 1'h0;
		waitDone;
		// limit initiators, fail-safe low
		axiWrite(ADDR_CTRL, 32'h0);
		limitPosIn <= 1'h0;
		repeat (2) @(posedge clk);
		`CHK(brakeOut, 1'h1, "limit brake")
		regCheck(ADDR_STATUS, 32'hD0, 32'h50);
		regCheck(ADDR_ERRNUM, 32'hFFFF, {16'h0, ERR_LIMPOS});
		axiWrite(ADDR_CTRL, 32'h10);
		`CHK(brakeOut, 1'h0, "manual may leave")
		axiWrite(ADDR_CTRL, 32'h0);
		limitPosIn <= 1'h1;
		limitNegIn <= 1'h0;
		repeat (2) @(posedge clk);
		regCheck(ADDR_ERRNUM, 32'hFFFF, {16'h0, ERR_LIMNEG});
		limitNegIn <= 1'h1;
		giveVerdict();
	end
endmodule
